//--- common/kds_defs.vh
// Constants shared by the keyboard/display scanner files
`ifndef KDS_DEFS_VH
`define KDS_DEFS_VH
// Command codes in the top three bits of a command byte
`define KDS_CMD_MODE 3'h0
`define KDS_CMD_CLOCK 3'h1
`define KDS_CMD_RDFIFO 3'h2
`define KDS_CMD_RDDISP 3'h3
`define KDS_CMD_WRDISP 3'h4
`define KDS_CMD_BLANK 3'h5
`define KDS_CMD_CLEAR 3'h6
`define KDS_CMD_ENDINT 3'h7
// Reset values
`define KDS_RST_DISP_MODE 2'h1
`define KDS_RST_KEY_MODE 3'h0
`define KDS_RST_PRESCALE 5'h1F
`define KDS_MIN_PRESCALE 5'h02
// Key mode field: bit 0 decoded scan, bit 1 rollover, upper pair selects input kind
`define KDS_KEY_SENSOR 2'h2
`define KDS_KEY_STROBED 2'h3
// Scan timing in base ticks
`define KDS_ROW_TICKS 7'h40
`define KDS_BLANK_TICKS 7'h04
`define KDS_DEBOUNCE_SCANS 2'h2
`define KDS_LAST_ENC_ROW 3'h7
`define KDS_LAST_DEC_ROW 3'h3
// Blank codes chosen by the clear command
`define KDS_BLANK_ZERO 8'h00
`define KDS_BLANK_SPACE 8'h20
`define KDS_BLANK_ONES 8'hFF
`define KDS_LAST_DISP_ROW 4'hF
// Idle level of the synchronised pin vector
`define KDS_PIN_IDLE 23'h3FFFFF
`endif

//--- hdl/kds_fifo.v
// Eight-entry character FIFO that doubles as the sensor RAM
`timescale 1ns/1ps
module kds_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_clear,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output reg [WIDTH-1:0] o_out_data,
    output reg [AW:0] o_count,
    input wire i_direct,
    input wire i_direct_we,
    input wire [AW-1:0] i_direct_waddr,
    input wire [AW-1:0] i_direct_raddr
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    wire push;
    wire pop;

    assign o_in_ready = (o_count != DEPTH[AW:0]);
    assign o_out_valid = (o_count != {(AW+1){1'b0}});
    assign push = i_in_valid & o_in_ready & ~i_direct;
    assign pop = i_out_ready & o_out_valid & ~i_direct;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge i_clock) begin
        if (!i_rst_n || i_clear) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            o_count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                o_count <= o_count + 1'b1;
            end else if (pop && !push) begin
                o_count <= o_count - 1'b1;
            end
        end
    end

    // Read data lags the pointer by one cycle; host strobes are slower
    always @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
        if (i_direct && i_direct_we) begin
            mem[i_direct_waddr] <= i_in_data;
        end
        o_out_data <= i_direct ? mem[i_direct_raddr] : mem[rd_ptr];
    end
endmodule // kds_fifo

//--- hdl/kds_top.v
// Keyboard/display scanner: host port, timing chain, key scan, display refresh
`timescale 1ns/1ps
`include "kds_defs.vh"
module kds_top #(
    parameter DATA_W = 8,
    parameter FIFO_DEPTH = 8
) (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_reset,
    input wire i_cs_n,
    input wire i_cmd_data_select,
    input wire i_rd_n,
    input wire i_wr_n,
    input wire [7:0] i_host_data_bus,
    output reg [7:0] o_host_data_bus,
    output reg o_host_data_oe,
    output reg o_irq,
    output reg [3:0] o_scan_lines,
    input wire [7:0] i_return_lines,
    input wire i_shift,
    input wire i_control_strobe_in,
    output reg [3:0] o_display_port_a,
    output reg [3:0] o_display_port_b,
    output reg o_blank_display_n
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; every pin here is asynchronous to the clock
    reg [22:0] pins_meta;
    reg [22:0] pins;
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            pins_meta <= `KDS_PIN_IDLE;
            pins <= `KDS_PIN_IDLE;
        end else begin
            pins_meta <= {i_reset, i_cs_n, i_cmd_data_select, i_rd_n, i_wr_n,
                          i_host_data_bus, i_return_lines, i_shift, i_control_strobe_in};
            pins <= pins_meta;
        end
    end
    wire cs_n = pins[21];
    wire a0 = pins[20];
    wire rd_n = pins[19];
    wire wr_n = pins[18];
    wire [7:0] db = pins[17:10];
    wire [7:0] rl = pins[9:2];
    wire shift = pins[1];
    wire cntl = pins[0];
    wire rst = !i_rst_n || pins[22];

    ////////////////////////////////////////////////////////////////////////
    // Configuration and host-port state
    reg [1:0] disp_mode;
    reg [2:0] key_mode;
    reg [4:0] prescale_value;
    reg rd_src_disp, disp_ai, sens_ai, err_mode;
    reg [3:0] disp_addr;
    reg [2:0] sens_addr;
    reg inhibit_a, inhibit_b, blank_a, blank_b;
    reg [7:0] blank_code;
    reg clear_busy;
    reg [3:0] clr_idx;
    reg overrun, underrun, sens_irq, resync, fifo_clear;
    reg wr_prev, rd_prev, cntl_prev, wr_armed, rd_armed, wr_a0, rd_a0;
    reg [7:0] wr_data;
    reg [7:0] disp_ram [0:15];
    reg [7:0] shadow [0:7];

    wire sensor_mode = (key_mode[2:1] == `KDS_KEY_SENSOR);
    wire strobed_mode = (key_mode[2:1] == `KDS_KEY_STROBED);
    wire keyboard_mode = ~key_mode[2];
    wire decoded = key_mode[0];
    wire wr_evt = wr_armed && wr_n && !wr_prev;
    wire rd_evt = rd_armed && rd_n && !rd_prev;
    wire data_rd = rd_evt && !rd_a0;
    wire fifo_pop = data_rd && !rd_src_disp && !sensor_mode;
    wire fifo_valid, fifo_ready;
    wire [7:0] fifo_dout;
    wire [3:0] fifo_count;
    reg key_push, strobe_push, sens_we;
    reg [7:0] key_byte;
    wire push_valid = key_push || strobe_push;
    wire [4:0] eff_prescale;
    reg [3:0] scan;
    // zero or one act as two
    assign eff_prescale = (prescale_value < `KDS_MIN_PRESCALE) ? `KDS_MIN_PRESCALE
                                                              : prescale_value;

    ////////////////////////////////////////////////////////////////////////
    // Host strobes, commands, display RAM writes and clearing
    always @(posedge i_clock) begin
        fifo_clear <= 1'b0;
        resync <= 1'b0;
        if (rst) begin
            key_mode <= `KDS_RST_KEY_MODE;
            prescale_value <= `KDS_RST_PRESCALE;
            disp_mode <= `KDS_RST_DISP_MODE;
            {rd_src_disp, disp_ai, sens_ai, err_mode} <= 4'h0;
            disp_addr <= 4'h0;
            sens_addr <= 3'h0;
            {inhibit_a, inhibit_b, blank_a, blank_b} <= 4'h0;
            blank_code <= `KDS_BLANK_ZERO;
            {clear_busy, overrun, underrun, sens_irq} <= 4'h0;
            clr_idx <= 4'h0;
            {wr_prev, rd_prev, wr_armed, rd_armed, wr_a0, rd_a0} <= 6'h3C;
            wr_data <= 8'h00;
        end else begin
            wr_prev <= wr_n;
            rd_prev <= rd_n;
            // strobes count only while chip select is low
            if (!cs_n && !wr_n) begin
                wr_armed <= 1'b1;
                wr_a0 <= a0;
                wr_data <= db;
            end else if (wr_n) begin
                wr_armed <= 1'b0;
            end
            if (!cs_n && !rd_n) begin
                rd_armed <= 1'b1;
                rd_a0 <= a0;
            end else if (rd_n) begin
                rd_armed <= 1'b0;
            end
            if (clear_busy) begin
                disp_ram[clr_idx] <= blank_code;
                clr_idx <= clr_idx + 4'h1;
                clear_busy <= (clr_idx != `KDS_LAST_DISP_ROW);
            end
            if (wr_evt && wr_a0) begin
                case (wr_data[7:5])
                    `KDS_CMD_MODE: begin
                        disp_mode <= wr_data[4:3];
                        key_mode <= wr_data[2:0];
                    end
                    `KDS_CMD_CLOCK: begin
                        prescale_value <= wr_data[4:0];
                    end
                    `KDS_CMD_RDFIFO: begin
                        rd_src_disp <= 1'b0;
                        sens_ai <= wr_data[4];
                        sens_addr <= wr_data[2:0];
                    end
                    `KDS_CMD_RDDISP: begin
                        rd_src_disp <= 1'b1;
                        disp_ai <= wr_data[4];
                        disp_addr <= wr_data[3:0];
                    end
                    `KDS_CMD_WRDISP: begin
                        disp_ai <= wr_data[4];
                        disp_addr <= wr_data[3:0];
                    end
                    `KDS_CMD_BLANK: begin
                        {inhibit_a, inhibit_b, blank_a, blank_b} <= wr_data[3:0];
                    end
                    `KDS_CMD_CLEAR: begin
                        if (wr_data[4]) begin
                            blank_code <= !wr_data[3] ? `KDS_BLANK_ZERO :
                                !wr_data[2] ? `KDS_BLANK_SPACE : `KDS_BLANK_ONES;
                        end
                        if (wr_data[4] || wr_data[0]) begin
                            clear_busy <= 1'b1;
                            clr_idx <= 4'h0;
                        end
                        if (wr_data[1] || wr_data[0]) begin
                            fifo_clear <= 1'b1;
                            {overrun, underrun, sens_irq} <= 3'h0;
                            sens_addr <= 3'h0;
                        end
                        resync <= wr_data[0];
                    end
                    `KDS_CMD_ENDINT: begin
                        sens_irq <= 1'b0;
                        err_mode <= wr_data[4];
                    end
                    default: begin
                    end
                endcase
            end else if (wr_evt && !clear_busy) begin
                disp_ram[disp_addr] <= {inhibit_a ? disp_ram[disp_addr][7:4] : wr_data[7:4],
                                        inhibit_b ? disp_ram[disp_addr][3:0] : wr_data[3:0]};
                disp_addr <= disp_addr + {3'h0, disp_ai};
            end
            if (data_rd && rd_src_disp) begin
                disp_addr <= disp_addr + {3'h0, disp_ai};
            end
            if (data_rd && !rd_src_disp && sensor_mode) begin
                sens_addr <= sens_addr + {2'h0, sens_ai};
            end
            // underrun on empty read, overrun on full push; set wins
            if (fifo_pop && !fifo_valid) begin
                underrun <= 1'b1;
            end
            if (push_valid && !fifo_ready) begin
                overrun <= 1'b1;
            end
            // any change in the sensor rows
            if (sens_we && (rl != shadow[scan[2:0]])) begin
                sens_irq <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timing chain: prescaler, row ticks and scan counter
    reg [4:0] presc_cnt;
    reg [6:0] tick_cnt;
    reg [1:0] kb_scans;
    wire tick = (presc_cnt >= eff_prescale - 5'h01);
    wire row_end = tick && (tick_cnt == `KDS_ROW_TICKS - 7'h01);
    wire [2:0] row = decoded ? {1'b0, scan[1:0]} : scan[2:0];
    wire last_row = (row == (decoded ? `KDS_LAST_DEC_ROW : `KDS_LAST_ENC_ROW));
    // divide-by-N base tick, rows of fixed tick count
    always @(posedge i_clock) begin
        if (rst || resync) begin
            presc_cnt <= 5'h00;
            tick_cnt <= 7'h00;
            scan <= 4'h0;
        end else begin
            presc_cnt <= tick ? 5'h00 : presc_cnt + 5'h01;
            if (tick) begin
                tick_cnt <= row_end ? 7'h00 : tick_cnt + 7'h01;
            end
            if (row_end) begin
                scan <= scan + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Key debounce, strobed capture and sensor row copy
    reg kb_busy, kb_hold;
    reg [2:0] kb_row, kb_col, first_col;
    reg [7:0] key_src;
    integer i;
    wire closed = (rl != 8'hFF);
    wire col_hit = !rl[kb_col];
    always @* begin
        first_col = 3'h0;
        for (i = 7; i >= 0; i = i - 1) begin
            if (!rl[i]) begin
                first_col = i[2:0];
            end
        end
    end
    always @(posedge i_clock) begin
        key_push <= 1'b0;
        strobe_push <= 1'b0;
        sens_we <= 1'b0;
        if (rst || fifo_clear) begin
            {kb_busy, kb_hold, cntl_prev} <= 3'h1;
            {kb_row, kb_col} <= 6'h00;
            kb_scans <= 2'h0;
            key_byte <= 8'h00;
        end else begin
            cntl_prev <= cntl;
            // strobe rising edge loads return lines
            if (strobed_mode && cntl && !cntl_prev) begin
                strobe_push <= 1'b1;
                key_byte <= rl;
            end
            // sensor rows copied each scan, held while interrupt is up
            if (sensor_mode && row_end && !sens_irq && !o_irq) begin
                sens_we <= 1'b1;
                key_byte <= rl;
                shadow[row] <= rl;
            end
            if (keyboard_mode && row_end) begin
                if (last_row && kb_busy && kb_scans != `KDS_DEBOUNCE_SCANS) begin
                    kb_scans <= kb_scans + 2'h1;
                end
                if (kb_hold) begin
                    kb_hold <= !(row == kb_row && !col_hit);
                end else if (!kb_busy && closed) begin
                    {kb_busy, kb_row, kb_col, kb_scans} <= {1'b1, row, first_col, 2'h0};
                end else if (kb_busy && row == kb_row && kb_scans == `KDS_DEBOUNCE_SCANS) begin
                    // accept only if still closed after debounce
                    kb_busy <= 1'b0;
                    kb_hold <= col_hit;
                    key_push <= col_hit;
                    key_byte <= {cntl, shift, kb_row, kb_col};
                end else if (kb_busy && row == kb_row && !col_hit) begin
                    kb_busy <= 1'b0;
                end else if (kb_busy && closed && !key_mode[1] &&
                             (row != kb_row || rl != ~(8'h01 << kb_col))) begin
                    // Lockout: a second closure restarts debounce on it
                    {kb_row, kb_col, kb_scans} <= {row, first_col, 2'h0};
                end
            end
        end
    end

    kds_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .i_clock(i_clock),
        .i_rst_n(!rst),
        .i_clear(fifo_clear),
        .i_in_valid(push_valid),
        .o_in_ready(fifo_ready),
        .i_in_data(key_byte),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_dout),
        .o_count(fifo_count),
        .i_direct(sensor_mode),
        .i_direct_we(sens_we),
        .i_direct_waddr(row),
        .i_direct_raddr(sens_addr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Host read data, interrupt and display outputs
    reg any_closed;
    integer r;
    always @* begin
        any_closed = 1'b0;
        for (r = 0; r < 8; r = r + 1) begin
            any_closed = any_closed | (shadow[r] != 8'hFF);
        end
    end
    // busy, closure/error, overrun, underrun, full, count
    wire [7:0] status = {clear_busy, err_mode & any_closed & sensor_mode, overrun,
                         underrun, !fifo_ready, fifo_count[2:0]};
    wire [3:0] disp_idx = decoded ? {2'h0, scan[1:0]} : scan;
    always @(posedge i_clock) begin
        if (rst) begin
            o_host_data_bus <= 8'h00;
            o_host_data_oe <= 1'b0;
            o_irq <= 1'b0;
            o_scan_lines <= 4'h0;
            o_display_port_a <= 4'h0;
            o_display_port_b <= 4'h0;
            o_blank_display_n <= 1'b0;
        end else begin
            // drive while selected and reading; released otherwise
            o_host_data_oe <= !cs_n && !rd_n;
            o_host_data_bus <= a0 ? status : (rd_src_disp ? disp_ram[disp_addr] : fifo_dout);
            // FIFO interrupt drops during each FIFO data read, not display RAM reads; sensor flag
            o_irq <= sensor_mode ? sens_irq
                   : (fifo_valid && !(rd_armed && !rd_a0 && !rd_src_disp));
            // binary count or one of four
            o_scan_lines <= decoded ? (4'h1 << scan[1:0]) : scan;
            // nibbles follow the scan index, blanked apart
            o_display_port_a <= blank_a ? blank_code[7:4] : disp_ram[disp_idx][7:4];
            o_display_port_b <= blank_b ? blank_code[3:0] : disp_ram[disp_idx][3:0];
            // blank at digit switch or when both nibbles blanked
            o_blank_display_n <= !(tick_cnt < `KDS_BLANK_TICKS) && !(blank_a && blank_b);
        end
    end
endmodule // kds_top

//--- verification/kds_chk.sv
// Port assertions for the keyboard/display scanner
`timescale 1ns/1ps
module kds_chk (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_reset,
    input wire i_cs_n,
    input wire i_rd_n,
    input wire o_host_data_oe,
    input wire o_irq,
    input wire [3:0] o_scan_lines,
    input wire [3:0] o_display_port_a,
    input wire [3:0] o_display_port_b,
    input wire o_blank_display_n
);
    reg [5:0] quiet_cs;
    reg [3:0] quiet_rd;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n || i_reset);
    ////////////////////////////////////////
    // Saturating idle counters, so long idle never wraps
    always @(posedge i_clock) begin
        if (!i_rst_n || !i_cs_n) begin
            quiet_cs <= 6'h00;
        end else if (quiet_cs != 6'h3F) begin
            quiet_cs <= quiet_cs + 6'h01;
        end
        if (!i_rst_n || (!i_cs_n && !i_rd_n)) begin
            quiet_rd <= 4'h0;
        end else if (quiet_rd != 4'hF) begin
            quiet_rd <= quiet_rd + 4'h1;
        end
    end
    ////////////////////////////////////////
    chk_reset_quiet: assert property (disable iff (1'b0)
        $rose(i_rst_n) |-> !o_irq && !o_host_data_oe && o_scan_lines == 4'h0
        && !o_blank_display_n) else $error("outputs not quiet after reset");
    chk_cs_off: assert property (
        i_cs_n [*5] |-> !o_host_data_oe) else $error("bus driven while deselected");
    chk_oe_needs_rd: assert property (
        o_host_data_oe |-> quiet_rd < 4'h6) else $error("bus driven without read");
    chk_oe_on_read: assert property (
        (!i_cs_n && !i_rd_n) [*6] |-> o_host_data_oe) else $error("read not driven");
    chk_irq_host_fall: assert property (
        $fell(o_irq) |-> quiet_cs < 6'h0A) else $error("irq fell with host idle");
    chk_scan_step: assert property (
        $changed(o_scan_lines) |-> o_scan_lines == $past(o_scan_lines) + 4'h1
        || o_scan_lines == 4'h0 || $onehot(o_scan_lines)) else $error("bad scan step");
    chk_blank_width: assert property (
        $rose(o_blank_display_n) |-> !$past(o_blank_display_n, 5))
        else $error("blank pulse too short");
    chk_port_blanked: assert property (
        ($changed(o_display_port_a) || $changed(o_display_port_b)) && quiet_cs == 6'h3F
        |-> !o_blank_display_n || !$past(o_blank_display_n)) else $error("port changed lit");
    cover property ($rose(o_irq));
    cover property ($fell(o_irq));
    cover property (o_scan_lines == 4'h8 && o_blank_display_n);
endmodule // kds_chk

//--- verification/kds_host_model.sv
// Host processor model on the scanner bus
`timescale 1ns/1ps
module kds_host_model (
    input wire i_clock,
    input wire [7:0] i_rdata,
    output reg o_cs_n,
    output reg o_a0,
    output reg o_rd_n,
    output reg o_wr_n,
    output reg [7:0] o_data
);
    initial begin
        o_cs_n = 1'b1;
        o_a0 = 1'b0;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_data = 8'h00;
    end
    ////////////////////////////////////////
    // select marks command or RAM
    task put(input reg cs, input reg a, input reg [7:0] d);
        begin
            @(posedge i_clock);
            o_cs_n <= cs;
            o_a0 <= a;
            o_data <= d;
            o_wr_n <= 1'b0;
            repeat (5) @(posedge i_clock);
            o_wr_n <= 1'b1;
            // Hold past the input synchroniser
            repeat (4) @(posedge i_clock);
            o_cs_n <= 1'b1;
            o_data <= ~d;
            repeat (4) @(posedge i_clock);
        end
    endtask
    task get(input reg a, output reg [7:0] d);
        begin
            @(posedge i_clock);
            o_cs_n <= 1'b0;
            o_a0 <= a;
            o_rd_n <= 1'b0;
            repeat (7) @(posedge i_clock);
            d = i_rdata;
            o_rd_n <= 1'b1;
            o_cs_n <= 1'b1;
            repeat (5) @(posedge i_clock);
        end
    endtask
endmodule // kds_host_model

//--- verification/kds_top_tb.sv
// Self-checking bench for the keyboard/display scanner
`timescale 1ns/1ps
module kds_top_tb;
    reg i_clock, i_rst_n, i_reset, i_shift, i_control_strobe_in, use_keys;
    reg [7:0] i_return_lines, sdata, got;
    reg [15:0] lfsr;
    reg [3:0] krow;
    reg [2:0] kcol;
    reg [7:0] q [0:7];
    reg [7:0] disp [0:3];
    integer n_fail, total_checks, i, j, cnt, idx;
    wire cs_n, a0, rd_n, wr_n, oe, irq, bd_n;
    wire [7:0] hdata, dout, bus;
    wire [3:0] scan, pa, pb;
    assign bus = oe ? dout : hdata;
    kds_top dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reset(i_reset), .i_cs_n(cs_n),
        .i_cmd_data_select(a0), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_host_data_bus(bus),
        .o_host_data_bus(dout), .o_host_data_oe(oe), .o_irq(irq), .o_scan_lines(scan),
        .i_return_lines(i_return_lines), .i_shift(i_shift),
        .i_control_strobe_in(i_control_strobe_in), .o_display_port_a(pa),
        .o_display_port_b(pb), .o_blank_display_n(bd_n));
    kds_host_model host (.i_clock(i_clock), .i_rdata(bus), .o_cs_n(cs_n), .o_a0(a0),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(hdata));
    ////////////////////////////////////////
    function [15:0] step(input [15:0] x);
        step = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function [7:0] stat(input ov, input un, input [3:0] n);
        stat = {2'h0, ov, un, n[3], n[2:0]};
    endfunction
    task chk(input [63:0] nm, input [11:0] e, input [11:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("Error %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    // Cycles until the scan lines move, bounded
    task nextrow(output integer n);
        reg [3:0] s;
        begin
            s = scan;
            n = 0;
            while (scan === s) begin
                @(posedge i_clock);
                n = n + 1;
                if (n > 4000) begin
                    n_fail = n_fail + 1;
                    summarize;
                end
            end
        end
    endtask
    ////////////////////////////////////////
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    // Key matrix: one closed switch pulls its column low on its row
    always @(posedge i_clock) begin
        // Keyboard rows decode only the low three scan lines
        i_return_lines <= use_keys ? ((scan[2:0] === krow[2:0]) ? ~(8'h01 << kcol) : 8'hFF)
                                   : sdata;
    end
    initial begin
        {n_fail, total_checks} = 0;
        {i_rst_n, i_reset, use_keys, krow, kcol} = 0;
        {i_shift, i_control_strobe_in, i_return_lines, sdata} = 11'h7FF;
        lfsr = 16'h85DB;
        repeat (4) @(posedge i_clock);
        i_rst_n <= 1'b1;
        host.put(0, 1, 8'h0E);
        for (i = 0; i < 9; i = i + 1) begin
            lfsr = step(lfsr);
            if (i < 8) q[i] = lfsr[7:0];
            sdata <= lfsr[7:0];
            repeat (2) @(posedge i_clock);
            i_control_strobe_in <= 1'b0;
            repeat (6) @(posedge i_clock);
            i_control_strobe_in <= 1'b1;
            repeat (6) @(posedge i_clock);
        end
        host.get(1, got);
        chk("status", stat(1, 0, 8), {4'h0, got});
        chk("irq", 12'h001, {11'h0, irq});
        host.put(1, 1, 8'hC2);
        host.get(1, got);
        chk("cs_off", stat(1, 0, 8), {4'h0, got});
        host.put(0, 1, 8'h40);
        for (i = 0; i < 9; i = i + 1) begin
            host.get(0, got);
            if (i < 8) chk("fifo", {4'h0, q[i]}, {4'h0, got});
            if (i < 7) chk("irq", 12'h001, {11'h0, irq});
        end
        host.get(1, got);
        chk("status", stat(1, 1, 0), {4'h0, got});
        chk("irq", 12'h000, {11'h0, irq});
        host.put(0, 1, 8'hC2);
        host.get(1, got);
        chk("clear", 12'h000, {4'h0, got});
        $display("test strobed fifo done");
        // Open matrix, so keyboard mode after reset sees no closure
        sdata <= 8'hFF;
        i_reset <= 1'b1;
        repeat (4) @(posedge i_clock);
        i_reset <= 1'b0;
        // Let the reset pin pass its synchroniser before timing a row
        repeat (3) @(posedge i_clock);
        nextrow(cnt);
        chk("row0", 12'h07C, cnt >> 4);
        host.put(0, 1, 8'h20);
        nextrow(cnt);
        nextrow(cnt);
        chk("row", 12'h080, cnt);
        $display("test timing done");
        lfsr = step(lfsr);
        krow <= {1'b0, lfsr[5:3]};
        kcol <= lfsr[2:0];
        i_shift <= 1'b0;
        use_keys <= 1'b1;
        cnt = 0;
        while (irq !== 1'b1 && cnt < 20000) begin
            @(posedge i_clock);
            cnt = cnt + 1;
        end
        if (cnt == 20000) begin
            n_fail = n_fail + 1;
            summarize;
        end
        use_keys <= 1'b0;
        i_shift <= 1'b1;
        host.put(0, 1, 8'h40);
        host.get(0, got);
        chk("key", {4'h0, 2'h2, lfsr[5:0]}, {4'h0, got});
        $display("test key scan done");
        host.put(0, 1, 8'h90);
        for (i = 0; i < 4; i = i + 1) begin
            lfsr = step(lfsr);
            disp[i] = lfsr[7:0];
            host.put(0, 0, disp[i]);
        end
        host.put(0, 1, 8'h09);
        for (i = 0; i < 5; i = i + 1) begin
            nextrow(cnt);
            repeat (20) @(posedge i_clock);
            idx = 0;
            for (j = 0; j < 4; j = j + 1) if (scan === (4'h1 << j)) idx = j;
            chk("onehot", 12'h001, {11'h0, $onehot(scan)});
            chk("port", {4'h0, disp[idx]}, {4'h0, pa, pb});
            chk("blank", 12'h001, {11'h0, bd_n});
        end
        host.put(0, 1, 8'h70);
        for (i = 0; i < 4; i = i + 1) begin
            host.get(0, got);
            chk("dread", {4'h0, disp[i]}, {4'h0, got});
        end
        $display("test display done");
        summarize;
    end
endmodule // kds_top_tb

bind kds_top kds_chk u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reset(i_reset),
    .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .o_host_data_oe(o_host_data_oe), .o_irq(o_irq),
    .o_scan_lines(o_scan_lines), .o_display_port_a(o_display_port_a),
    .o_display_port_b(o_display_port_b), .o_blank_display_n(o_blank_display_n));
